// ---- pin_mode_defines.vh ----
`ifndef PIN_MODE_DEFINES_VH
`define PIN_MODE_DEFINES_VH
// Index ports
`define IDX_ADDR_PORT       16'h0022
`define IDX_DATA_PORT       16'h0023
// Configuration register indices
`define IDX_CFG_ID          8'h02
`define IDX_MODE_SELECT     8'h40
`define IDX_BIOS_LOW        8'h42
`define IDX_BIOS_HIGH       8'h43
`define CFG_ID_KEY          8'h0F
// Reset values
`define MODE_SELECT_RESET   8'h20
`define BIOS_LOW_RESET      8'h10
`define BIOS_HIGH_RESET     8'h00
// Writable masks
`define MODE_SELECT_MASK    8'h7F
`define BIOS_LOW_MASK       8'h3F
`define BIOS_HIGH_MASK      8'h0F
// Mode select fields
`define MS_GPCS_BIT         4
`define MS_SERR_BIT         3
`define MS_MUX_HI           2
`define MS_MUX_LO           0
// BIOS low fields and BIOS high write enable
`define BL_ENLARGED_BIT     5
`define BL_HIGH_BIT         4
`define BL_LOW4_BIT         3
`define BL_LOW3_BIT         2
`define BL_LOW2_BIT         1
`define BL_LOW1_BIT         0
`define BH_WRITE_EN_BIT     3
// Mux codes
`define MUX_ALL_IRQ         3'h0
`define MUX_IRQ01           3'h1
`define MUX_IRQ0            3'h2
`define MUX_XBUS            3'h3
`define MUX_DECODED         3'h4
`define MUX_REQ_IRQ01       3'h5
`define MUX_REQ_IRQ0        3'h6
`define MUX_ALL_REQ         3'h7
// Request pin patterns, bit 3 is request pin 7
`define REQ_NONE_IRQ        4'h0
`define REQ_ALL_IRQ         4'hF
`define REQ_IRQ01           4'hC
`define REQ_IRQ0            4'h8
// BIOS alias blocks on address bits 31:16
`define BLK_LOW_1M          16'h000E
`define BLK_LOW_16M         16'h00FE
`define BLK_LOW_4G_A        16'hFFEE
`define BLK_LOW_4G_B        16'hFFFE
`define BLK_HIGH_1M         16'h000F
`define BLK_HIGH_16M        16'h00FF
`define BLK_HIGH_4G         16'hFFFF
// Enlarged range on bits 31:19, top 128 KB excluded via bits 18:17
`define ENL_TOP             13'h1FFF
`define ENL_EXCL            2'h3
// 16 KB block codes on bits 15:14
`define SUB_LOW4            2'h3
`define SUB_LOW3            2'h2
`define SUB_LOW2            2'h1
`define SUB_LOW1            2'h0
`endif

// ---- bios_range_decode.v ----
`timescale 1ns/1ps
`include "pin_mode_defines.vh"
module bios_range_decode (
  input  wire [31:0] addr,
  input  wire [7:0]  bios_low,
  output wire        hit
);
  wire [15:0] blk = addr[31:16];
  wire [1:0]  sub = addr[15:14];
  wire low_area   = (blk == `BLK_LOW_1M) || (blk == `BLK_LOW_16M) || (blk == `BLK_LOW_4G_A) || (blk == `BLK_LOW_4G_B);
  wire high_area  = (blk == `BLK_HIGH_1M) || (blk == `BLK_HIGH_16M) || (blk == `BLK_HIGH_4G);
  wire enlarged   = (addr[31:19] == `ENL_TOP) && (addr[18:17] != `ENL_EXCL);
  assign hit = (bios_low[`BL_ENLARGED_BIT] && enlarged)
             | (bios_low[`BL_HIGH_BIT] && high_area)
             | (bios_low[`BL_LOW4_BIT] && low_area && (sub == `SUB_LOW4))
             | (bios_low[`BL_LOW3_BIT] && low_area && (sub == `SUB_LOW3))
             | (bios_low[`BL_LOW2_BIT] && low_area && (sub == `SUB_LOW2))
             | (bios_low[`BL_LOW1_BIT] && low_area && (sub == `SUB_LOW1));
endmodule // bios_range_decode

// ---- pin_mode_and_bios_select_cfg.v ----
`timescale 1ns/1ps
`include "pin_mode_defines.vh"
// Contract
// - Mode bit 4 picks separate spare chip selects at 0 and an encoded chip select at 1.
// - With mode bit 3 set and NMI globally enabled, a system error pulse raises NMI.
// - With mode bit 3 clear, system error never raises NMI from this source.
// - Mux codes 0 to 3 keep coded slot pins and requests 7-4, trading IRQ inputs for X-Bus strobes step by step.
// - Mux code 4 selects decoded enables and acks, IRQ inputs on the request pins, and all X-Bus strobes.
// - Codes 5 and 6 put IRQ inputs 0,1 or only 0 on request pins 7,6 or 7, with X-Bus strobes.
// - Code 7 selects coded slot pins, all four requests, X-Bus strobes and no IRQ inputs.
// - The BIOS select asserts on reads in an enabled range, and on writes only with write enable set.
// - Bit 5 of the low BIOS register enables the enlarged range.
// - Bit 4 enables the top 64 KB below 1 MB with its aliases, and is set after reset.
// - Bit 3 enables the fourth low 16 KB block with its aliases.
// - Bit 2 enables the third low 16 KB block with its aliases.
// - Bit 1 enables the second low 16 KB block with its aliases.
// - Bit 0 enables the first low 16 KB block with its aliases.
module pin_mode_and_bios_select_cfg (
  input  wire        clk,
  input  wire        reset,
  input  wire        io_write,
  input  wire        io_read,
  input  wire [15:0] io_addr,
  input  wire [7:0]  io_wdata,
  output reg  [7:0]  io_rdata,
  output wire        io_hit,
  input  wire        mem_read,
  input  wire        mem_write,
  input  wire [31:0] mem_addr,
  input  wire        nmi_global_enable,
  input  wire        system_error_n,
  output reg         nmi_serr,
  output reg         chip_select_encoded,
  output reg         coded_slot_enables,
  output reg         coded_slot_acks,
  output reg  [3:0]  req_pin_is_irq,
  output reg         disk_light,
  output reg         floppy_select,
  output reg         rtc_write_strobe,
  output reg         rtc_read_strobe,
  output reg         bios_chip_select_n
);
  reg  [7:0] index_reg;
  reg        unlocked_reg;
  reg  [7:0] pin_mode_select_reg;
  reg  [7:0] bios_select_low_reg;
  reg  [7:0] bios_select_high_reg;
  reg        serr_sync1_reg;
  reg        serr_sync2_reg;
  reg  [7:0] read_value;

  // Port compare shared by all strobe decodes
  function port_match;
    input [15:0] addr;
    input [15:0] port;
    begin
      port_match = (addr == port);
    end
  endfunction

  wire       bios_hit;
  wire [2:0] mux_code      = pin_mode_select_reg[`MS_MUX_HI:`MS_MUX_LO];
  wire       decoded_slots = (mux_code == `MUX_DECODED);
  wire       serr_enabled  = pin_mode_select_reg[`MS_SERR_BIT] && nmi_global_enable;
  wire       wr_addr       = io_write && port_match(io_addr, `IDX_ADDR_PORT);
  wire       wr_data       = io_write && port_match(io_addr, `IDX_DATA_PORT);
  wire       rd_addr       = io_read && port_match(io_addr, `IDX_ADDR_PORT);
  wire       rd_data       = io_read && port_match(io_addr, `IDX_DATA_PORT);

  assign io_hit = wr_addr || wr_data || rd_addr || rd_data;

  // Index and data port pair; data writes need the unlock key first

  always @(posedge clk) begin
    if (reset) begin
      index_reg            <= 8'h00;
      unlocked_reg         <= 1'b0;
      pin_mode_select_reg  <= `MODE_SELECT_RESET;
      bios_select_low_reg  <= `BIOS_LOW_RESET;
      bios_select_high_reg <= `BIOS_HIGH_RESET;
    end else begin
      if (wr_addr)
        index_reg <= io_wdata;
      if (wr_data && index_reg == `IDX_CFG_ID)
        unlocked_reg <= (io_wdata == `CFG_ID_KEY);
      if (wr_data && unlocked_reg) begin
        case (index_reg)
          `IDX_MODE_SELECT: pin_mode_select_reg  <= io_wdata & `MODE_SELECT_MASK;
          `IDX_BIOS_LOW:    bios_select_low_reg  <= io_wdata & `BIOS_LOW_MASK;
          `IDX_BIOS_HIGH:   bios_select_high_reg <= io_wdata & `BIOS_HIGH_MASK;
          default:          ;
        endcase
      end
    end
  end

  // Locked or unknown indices read as zero
  always @* begin
    case (index_reg)
      `IDX_CFG_ID:      read_value = unlocked_reg ? `CFG_ID_KEY : 8'h00;
      `IDX_MODE_SELECT: read_value = unlocked_reg ? pin_mode_select_reg : 8'h00;
      `IDX_BIOS_LOW:    read_value = unlocked_reg ? bios_select_low_reg : 8'h00;
      `IDX_BIOS_HIGH:   read_value = unlocked_reg ? bios_select_high_reg : 8'h00;
      default:          read_value = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      io_rdata <= 8'h00;
    end else if (rd_data) begin
      io_rdata <= read_value;
    end else if (rd_addr) begin
      io_rdata <= index_reg;
    end
  end

  // Two-flop synchroniser on the asynchronous error pin
  always @(posedge clk) begin
    if (reset) begin
      serr_sync1_reg <= 1'b0;
      serr_sync2_reg <= 1'b0;
      nmi_serr       <= 1'b0;
    end else begin
      serr_sync1_reg <= ~system_error_n;
      serr_sync2_reg <= serr_sync1_reg;
      nmi_serr       <= serr_enabled && serr_sync2_reg;
    end
  end

  bios_range_decode u_decode (
    .addr     (mem_addr),
    .bios_low (bios_select_low_reg),
    .hit      (bios_hit)
  );

  // Write enable widens the decode to memory writes
  always @(posedge clk) begin
    if (reset) begin
      bios_chip_select_n <= 1'b1;
    end else begin
      bios_chip_select_n <= ~(bios_hit && (mem_read ||
                              (mem_write && bios_select_high_reg[`BH_WRITE_EN_BIT])));
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      chip_select_encoded <= 1'b0;
      coded_slot_enables  <= 1'b1;
      coded_slot_acks     <= 1'b1;
      req_pin_is_irq      <= 4'h0;
      disk_light          <= 1'b0;
      floppy_select       <= 1'b0;
      rtc_write_strobe    <= 1'b0;
      rtc_read_strobe     <= 1'b0;
    end else begin
      chip_select_encoded <= pin_mode_select_reg[`MS_GPCS_BIT];
      coded_slot_enables  <= ~decoded_slots;
      coded_slot_acks     <= ~decoded_slots;
      // Pin mode flags, one per shared pin group
      case (mux_code)
        `MUX_ALL_IRQ: begin
          req_pin_is_irq   <= `REQ_NONE_IRQ;
          disk_light       <= 1'b0;
          floppy_select    <= 1'b0;
          rtc_write_strobe <= 1'b0;
          rtc_read_strobe  <= 1'b0;
        end
        `MUX_IRQ01: begin
          req_pin_is_irq   <= `REQ_NONE_IRQ;
          disk_light       <= 1'b0;
          floppy_select    <= 1'b0;
          rtc_write_strobe <= 1'b1;
          rtc_read_strobe  <= 1'b1;
        end
        `MUX_IRQ0: begin
          req_pin_is_irq   <= `REQ_NONE_IRQ;
          disk_light       <= 1'b0;
          floppy_select    <= 1'b1;
          rtc_write_strobe <= 1'b1;
          rtc_read_strobe  <= 1'b1;
        end
        `MUX_XBUS: begin
          req_pin_is_irq   <= `REQ_NONE_IRQ;
          disk_light       <= 1'b1;
          floppy_select    <= 1'b1;
          rtc_write_strobe <= 1'b1;
          rtc_read_strobe  <= 1'b1;
        end
        `MUX_DECODED: begin
          req_pin_is_irq   <= `REQ_ALL_IRQ;
          disk_light       <= 1'b1;
          floppy_select    <= 1'b1;
          rtc_write_strobe <= 1'b1;
          rtc_read_strobe  <= 1'b1;
        end
        `MUX_REQ_IRQ01: begin
          req_pin_is_irq   <= `REQ_IRQ01;
          disk_light       <= 1'b1;
          floppy_select    <= 1'b1;
          rtc_write_strobe <= 1'b1;
          rtc_read_strobe  <= 1'b1;
        end
        `MUX_REQ_IRQ0: begin
          req_pin_is_irq   <= `REQ_IRQ0;
          disk_light       <= 1'b1;
          floppy_select    <= 1'b1;
          rtc_write_strobe <= 1'b1;
          rtc_read_strobe  <= 1'b1;
        end
        default: begin
          req_pin_is_irq   <= `REQ_NONE_IRQ;
          disk_light       <= 1'b1;
          floppy_select    <= 1'b1;
          rtc_write_strobe <= 1'b1;
          rtc_read_strobe  <= 1'b1;
        end
      endcase
    end
  end
endmodule // pin_mode_and_bios_select_cfg

// ---- pin_mode_host.sv ----
`timescale 1ns/1ps
module pin_mode_host (
  input  logic        clk,
  output logic        io_write = 1'b0,
  output logic        io_read = 1'b0,
  output logic [15:0] io_addr = 16'h0022,
  output logic [7:0]  io_wdata = 8'h00,
  input  logic [7:0]  io_rdata
);
  task automatic cyc(input logic w, r, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 io_write = w;
    io_read = r;
    io_addr = a;
    io_wdata = d;
  endtask
  task automatic wr(input logic [7:0] idx, dat);
    cyc(1, 0, 16'h0022, idx);
    cyc(1, 0, 16'h0023, dat);
    cyc(0, 0, 16'h0023, ~dat);
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] dat);
    cyc(1, 0, 16'h0022, idx);
    cyc(0, 1, 16'h0023, ~idx);
    cyc(0, 0, 16'h0023, idx);
    dat = io_rdata;
  endtask
endmodule // pin_mode_host

// ---- pin_mode_and_bios_select_cfg_checker.sv ----
`timescale 1ns/1ps
module pin_mode_checker (
  input logic        clk,
  input logic        reset,
  input logic        mem_read,
  input logic        mem_write,
  input logic [31:0] mem_addr,
  input logic        nmi_global_enable,
  input logic        system_error_n,
  input logic        nmi_serr,
  input logic        coded_slot_enables,
  input logic        coded_slot_acks,
  input logic [3:0]  req_pin_is_irq,
  input logic        disk_light,
  input logic        floppy_select,
  input logic        rtc_write_strobe,
  input logic        rtc_read_strobe,
  input logic        bios_chip_select_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  idle_cs_a: assert property (!mem_read && !mem_write |=> bios_chip_select_n) else $error("cs idle");
  low_cs_a: assert property (mem_read && mem_addr < 32'h000E0000 |=> bios_chip_select_n) else $error("cs low");
  serr_quiet_a: assert property (system_error_n [*4] |=> !nmi_serr) else $error("nmi no serr");
  nmi_gate_a: assert property (!nmi_global_enable [*4] |=> !nmi_serr) else $error("nmi gated");
  slot_pair_a: assert property (coded_slot_enables == coded_slot_acks) else $error("slot pair");
  decoded_mux_a: assert property (!coded_slot_enables |-> req_pin_is_irq == 4'hF && disk_light) else $error("dec");
  xbus_step_a: assert property (disk_light |-> floppy_select && rtc_write_strobe && rtc_read_strobe) else $error("xb");
  irq_order_a: assert property (req_pin_is_irq[2] |-> req_pin_is_irq[3] && disk_light) else $error("irq");
endmodule // pin_mode_checker
bind pin_mode_and_bios_select_cfg pin_mode_checker i_chk (.clk(clk), .reset(reset), .mem_read(mem_read),
  .mem_write(mem_write), .mem_addr(mem_addr), .nmi_global_enable(nmi_global_enable), .system_error_n(system_error_n),
  .nmi_serr(nmi_serr), .coded_slot_enables(coded_slot_enables), .coded_slot_acks(coded_slot_acks),
  .req_pin_is_irq(req_pin_is_irq), .disk_light(disk_light), .floppy_select(floppy_select),
  .rtc_write_strobe(rtc_write_strobe), .rtc_read_strobe(rtc_read_strobe), .bios_chip_select_n(bios_chip_select_n));

// ---- pin_mode_and_bios_select_cfg_tb.sv ----
`timescale 1ns/1ps
module pin_mode_and_bios_select_cfg_tb;
  logic        clk = 0, reset = 1, mr = 0, mw = 0, ne = 0, se_n = 1;
  logic [31:0] ma = 0;
  logic        iw, ir, hit, nmi, cse, cen, cak, dl, fd, rw, rr, cs_n;
  logic [15:0] ia;
  logic [7:0]  wd, rd, d;
  logic [3:0]  irq;
  int          err_count = 0, cmp_count = 0;
  pin_mode_host i_host (.clk(clk), .io_write(iw), .io_read(ir), .io_addr(ia), .io_wdata(wd), .io_rdata(rd));
  pin_mode_and_bios_select_cfg i_dut (.clk(clk), .reset(reset), .io_write(iw), .io_read(ir), .io_addr(ia),
    .io_wdata(wd), .io_rdata(rd), .io_hit(hit), .mem_read(mr), .mem_write(mw), .mem_addr(ma),
    .nmi_global_enable(ne), .system_error_n(se_n), .nmi_serr(nmi), .chip_select_encoded(cse),
    .coded_slot_enables(cen), .coded_slot_acks(cak), .req_pin_is_irq(irq), .disk_light(dl),
    .floppy_select(fd), .rtc_write_strobe(rw), .rtc_read_strobe(rr), .bios_chip_select_n(cs_n));
  initial forever #10 clk = ~clk;
  task automatic chk(input string n, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic mem(input logic r, w, input logic [31:0] a, input logic e);
    @(posedge clk);
    #1 mr = r;
    mw = w;
    ma = a;
    @(posedge clk);
    #1 chk("cs_n", {7'h0, e}, {7'h0, cs_n});
    mr = 0;
    mw = 0;
  endtask
  task automatic t_mux;
    for (int c = 0; c < 8; c++) begin
      i_host.wr(8'h40, {3'h0, c[0], 1'b0, c[2:0]});
      @(posedge clk);
      #1 chk("enc", {7'h0, c[0]}, {7'h0, cse});
      chk("coded", {6'h0, c != 4, c != 4}, {6'h0, cen, cak});
      chk("irq", c == 4 ? 8'hF : c == 5 ? 8'hC : c == 6 ? 8'h8 : 8'h0, {4'h0, irq});
      chk("xbus", c == 0 ? 8'h0 : c == 1 ? 8'h3 : c == 2 ? 8'h7 : 8'hF, {4'h0, dl, fd, rw, rr});
    end
  endtask
  task automatic t_bios;
    logic [31:0] adr [6] = '{32'h000E0000, 32'hFFFE4000, 32'h000E8000, 32'hFFEEC000, 32'h00FF0000, 32'hFFF80000};
    for (int b = 0; b < 6; b++) begin
      i_host.wr(8'h42, 8'h01 << b);
      mem(1, 0, adr[b], 0);
      mem(1, 0, adr[(b + 1) % 6], 1);
    end
    mem(0, 1, adr[5], 1);
    i_host.wr(8'h43, 8'h08);
    mem(0, 1, adr[5], 0);
    i_host.wr(8'h42, 8'h11);
    mem(1, 0, adr[0], 0);
    mem(1, 0, 32'h000F0000, 0);
  endtask
  task automatic t_nmi;
    i_host.wr(8'h40, 8'h08);
    ne = 1;
    se_n = 0;
    repeat (4) @(posedge clk);
    #1 chk("nmi", 8'h1, {7'h0, nmi});
    se_n = 1;
    i_host.wr(8'h40, 8'h00);
    se_n = 0;
    repeat (4) @(posedge clk);
    #1 chk("nmi", 8'h0, {7'h0, nmi});
    se_n = 1;
  endtask
  task automatic tally_and_finish;
    if (err_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 reset = 0;
    mem(1, 0, 32'h000F0000, 0);
    i_host.rd(8'h40, d);
    chk("locked", 8'h00, d);
    i_host.wr(8'h02, 8'h0F);
    i_host.rd(8'h02, d);
    chk("cfg_id", 8'h0F, d);
    i_host.cyc(1, 0, 16'h0024, 8'h00);
    #1 chk("io_hit", 8'h0, {7'h0, hit});
    i_host.cyc(1, 0, 16'h0022, 8'h42);
    #1 chk("io_hit", 8'h1, {7'h0, hit});
    i_host.cyc(0, 0, 16'h0022, 8'h42);
    i_host.rd(8'h42, d);
    chk("bios_low", 8'h10, d);
    t_mux;
    t_bios;
    t_nmi;
    tally_and_finish;
  end
  initial begin
    #100000;
    err_count++;
    tally_and_finish;
  end
endmodule // pin_mode_and_bios_select_cfg_tb
